// ---- kpu_key_model.sv ----
// Far-side model of the keypad unit: five key switches and the CPU's vector fetch.
// Assumes the bench moves press and cpu_take just after the rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none

module kpu_key_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] press,
  input wire logic [4:0] pullup_en,
  input wire logic cpu_take,
  input wire logic irq_req,
  output logic [4:0] key_pin,
  output logic vector_fetch_ack
);
  // --------------------------------------------------------------------------
  // Pin levels.
  // --------------------------------------------------------------------------
  logic [4:0] drift;  // Level of an open pin with no pull-up; it flips every cycle.

  // An unpulled open pin must not look like a steady high, or faults would hide.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drift <= 5'h0a;
    end else begin
      drift <= ~drift;
    end
  end

  // A closed switch shorts the pin low; an open one is high under the pull-up, else it follows drift.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      key_pin[i] = press[i] ? 1'b0 : (pullup_en[i] ? 1'b1 : drift[i]);
    end
  end

  // --------------------------------------------------------------------------
  // CPU side.
  // --------------------------------------------------------------------------
  logic served;  // The CPU has fetched for this request and waits for it to drop.

  // When allowed, the CPU fetches the vector one cycle after it sees the request.
  // The request line lags the flag, so served is needed to keep the CPU to one fetch per request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_fetch_ack <= 1'b0;
      served <= 1'b0;
    end else begin
      vector_fetch_ack <= cpu_take && irq_req && !vector_fetch_ack && !served;
      served <= irq_req && (served || vector_fetch_ack);
    end
  end
endmodule : kpu_key_model
`default_nettype wire

// ---- kpu_keypad_unit.sv ----
// Keypad wake unit: five active-low wake pins, request latch, mask and AXI4-Lite registers.
// Assumes one 250 MHz clock; pins are asynchronous, CPU and break signals share the clock.
`include "kpu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module kpu_keypad_unit
  import kpu_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NPINS = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] key_pin,
  input wire logic vector_fetch_ack,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output var logic [NPINS-1:0] pin_wake_enable,
  output var logic [NPINS-1:0] pullup_en,
  output var logic [NPINS-1:0] force_input,
  output var logic irq_req
);

  // --------------------------------------------------------------------------
  // Address decode, shared by the read and write paths.
  // --------------------------------------------------------------------------

  // Returns {enable register hit, status register hit}; anything else is unmapped.
  function automatic logic [1:0] kpu_decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] scr_addr;
    logic [ADDR_W-1:0] ier_addr;
    scr_addr = ADDR_W'({`KPU_SCR_IDX, 2'b00});
    ier_addr = ADDR_W'({`KPU_IER_IDX, 2'b00});
    kpu_decode = {addr == ier_addr, addr == scr_addr};
  endfunction : kpu_decode

  // --------------------------------------------------------------------------
  // State declarations.
  // --------------------------------------------------------------------------
  logic [NPINS-1:0] pin_meta;      // First synchroniser stage, read by the second only.
  logic [NPINS-1:0] pin_sync;      // Second stage, the only copy logic may look at.
  logic prev_any_low;              // Whether some enabled pin was low a cycle ago.
  logic request_pending_flag;                      // The latched request.
  logic ack_pend;                  // Level mode: acknowledge seen while a pin is still low.
  logic [NPINS-1:0] enable;        // Per-pin wake enable.
  kpu_ctl_t ctl;                   // Mask and trigger mode.
  logic aw_got;                    // Write address captured.
  logic w_got;                     // Write data captured.
  logic [ADDR_W-1:0] aw_addr;      // Captured write address.
  kpu_wbeat_t wbeat;               // Captured write data and strobes.

  // Combinational terms.
  logic any_low;                   // Some enabled pin is low now.
  logic fall;                      // Enabled pins went from all high to some low.
  logic wr_do;                     // Write performed this cycle.
  logic [1:0] wr_hit;              // Decode of the captured write address.
  logic [1:0] rd_hit;              // Decode of the read address.
  logic ack_sw;                    // Software acknowledge that break rules allow.
  logic ack;                       // Any acknowledge this cycle.
  logic next_request_pending_flag;
  logic next_ack_pend;

  // --------------------------------------------------------------------------
  // Pin synchroniser.
  // --------------------------------------------------------------------------

  // Two flops per pin; key switches bounce and change at any time against the bus clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= key_pin;
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Trigger detection.
  // --------------------------------------------------------------------------

  // Only enabled pins take part; a disabled pin held low no longer blocks the others.
  assign any_low = |(~pin_sync & enable);
  // A new request needs every enabled pin high in the cycle before.
  assign fall = any_low && !prev_any_low;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_any_low <= 1'b0;
    end else begin
      prev_any_low <= any_low;
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge sources.
  // --------------------------------------------------------------------------

  assign wr_do = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit = kpu_decode(aw_addr);
  assign rd_hit = kpu_decode(s_axi_araddr);
  // In break with clearing disabled, acknowledge writes are simply dropped.
  assign ack_sw = wr_do && wr_hit[0] && wbeat.strb[0] && wbeat.data[`KPU_SCR_ACK]
                  && !(break_state && !break_clear_enable);
  assign ack = ack_sw || vector_fetch_ack;

  // --------------------------------------------------------------------------
  // Request latch.
  // --------------------------------------------------------------------------

  // A fresh fall always wins over an acknowledge in the same cycle.
  always_comb begin
    next_request_pending_flag = request_pending_flag;
    next_ack_pend = ack_pend;
    if (fall) begin
      next_request_pending_flag = 1'b1;
      next_ack_pend = 1'b0;
    end else if (!ctl.mode) begin
      next_ack_pend = 1'b0;
      if (ack) begin
        next_request_pending_flag = 1'b0;
      end
    end else if (any_low) begin
      // Level mode keeps the request while a pin is low; remember the acknowledge.
      if (ack && request_pending_flag) begin
        next_ack_pend = 1'b1;
      end
    end else if (ack || ack_pend) begin
      next_request_pending_flag = 1'b0;
      next_ack_pend = 1'b0;
    end
  end

  // Reset clears the request even with a pin held low, since every enable resets to zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_pending_flag <= 1'b0;
      ack_pend <= 1'b0;
    end else begin
      request_pending_flag <= next_request_pending_flag;
      ack_pend <= next_ack_pend;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt and wake output.
  // --------------------------------------------------------------------------

  // The same line wakes the CPU from wait and stop; nothing here depends on a low-power state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= request_pending_flag && !ctl.mask;
    end
  end

  // --------------------------------------------------------------------------
  // Software-written registers.
  // --------------------------------------------------------------------------

  // Only byte lane 0 carries register bits; other lanes are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= `KPU_IER_RST;
      ctl <= '0;
    end else if (wr_do && wbeat.strb[0]) begin
      if (wr_hit[1]) begin
        enable <= wbeat.data[NPINS-1:0];
      end
      if (wr_hit[0]) begin
        ctl.mask <= wbeat.data[`KPU_SCR_MASK];
        ctl.mode <= wbeat.data[`KPU_SCR_MODE];
      end
    end
  end

  // The enable register drives the pull-ups and the direction override straight.
  assign pin_wake_enable = enable;
  assign pullup_en = enable;
  assign force_input = enable;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel.
  // --------------------------------------------------------------------------

  // Address and data are captured independently, so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      wbeat <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wbeat <= '{data: s_axi_wdata, strb: s_axi_wstrb};
        s_axi_wready <= 1'b0;
      end
      // Readiness returns only when the response is taken: one write at a time.
      if (s_axi_bvalid && s_axi_bready) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // The response is raised the cycle after both halves are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `KPU_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (|wr_hit) ? `KPU_RESP_OKAY : `KPU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel.
  // --------------------------------------------------------------------------

  // Reads have no side effect; the acknowledge bit and upper bits always read zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `KPU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (|rd_hit) ? `KPU_RESP_OKAY : `KPU_RESP_SLVERR;
      s_axi_rdata <= '0;
      if (rd_hit[0]) begin
        s_axi_rdata[`KPU_SCR_REQUEST_PENDING_FLAG] <= request_pending_flag;
        s_axi_rdata[`KPU_SCR_MASK] <= ctl.mask;
        s_axi_rdata[`KPU_SCR_MODE] <= ctl.mode;
      end else if (rd_hit[1]) begin
        s_axi_rdata[NPINS-1:0] <= enable;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------

  chk_fall_latches: assert property (@(posedge aclk) disable iff (!aresetn)
    fall |=> request_pending_flag) else $error("Fall did not latch a request.");

  chk_edge_ack_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctl.mode && ack && !fall) |=> !request_pending_flag) else $error("Edge mode ack did not clear.");

  chk_level_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl.mode && request_pending_flag && any_low) |=> request_pending_flag) else $error("Level request dropped while pin low.");

  chk_level_ack_late: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl.mode && request_pending_flag && any_low && ack && !fall) ##1 (!any_low && ctl.mode)[*2] |-> ##1 !request_pending_flag)
    else $error("Level request not cleared after pins returned high.");

  chk_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.mask |=> !irq_req) else $error("Masked request reached the CPU.");

  chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (request_pending_flag && !ctl.mask) |=> irq_req) else $error("Unmasked request not presented.");

  chk_break_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (break_state && !break_clear_enable && !vector_fetch_ack && !ack_pend && request_pending_flag) |=> request_pending_flag)
    else $error("Ack took effect in protected break.");

  chk_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> (!request_pending_flag && !ctl.mode && !ctl.mask && enable == '0))
    else $error("Reset left state set.");

  chk_scr_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_hit[0]) |=> (s_axi_rdata[31:4] == '0 && !s_axi_rdata[2]))
    else $error("Reserved or ack bit read nonzero.");

  chk_pullup_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_hit[1] && wbeat.strb[0]) |=> pullup_en == $past(wbeat.data[NPINS-1:0]))
    else $error("Pull-ups did not follow the enable write.");

  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do |=> s_axi_bvalid) else $error("Write response missing.");

  // A pin already low in the previous cycle means there is no all-high state to fall from.
  chk_edge_fall_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctl.mode && prev_any_low && !request_pending_flag) |=> !request_pending_flag) else $error("Latched while a pin was low.");

  chk_vector_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctl.mode && vector_fetch_ack && !fall) |=> !request_pending_flag) else $error("Vector fetch did not acknowledge.");

  chk_flag_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_hit[0]) |=> s_axi_rdata[`KPU_SCR_REQUEST_PENDING_FLAG] == $past(request_pending_flag))
    else $error("Pending flag read back wrong.");

  cov_edge_request: cover property (@(posedge aclk) disable iff (!aresetn)
    !ctl.mode && fall ##2 irq_req);
  cov_level_ack_first: cover property (@(posedge aclk) disable iff (!aresetn)
    ctl.mode && request_pending_flag && any_low && ack ##[1:20] !request_pending_flag);
  cov_break_blocked: cover property (@(posedge aclk) disable iff (!aresetn)
    break_state && !break_clear_enable && ack_sw == 1'b0 && wr_do && wr_hit[0]);
  cov_vector_fetch: cover property (@(posedge aclk) disable iff (!aresetn)
    vector_fetch_ack && request_pending_flag ##1 !request_pending_flag);
  cov_level_pins_first: cover property (@(posedge aclk) disable iff (!aresetn)
    ctl.mode && request_pending_flag && !any_low && ack ##1 !request_pending_flag);

endmodule : kpu_keypad_unit

`default_nettype wire

// ---- kpu_pkg.sv ----
// Types shared by the keypad unit.
// Assumes the register header is on the include path.
package kpu_pkg;

  // --------------------------------------------------------------------------
  // Control bits that software writes in the status and control register.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic mask;  // Blocks the request from the CPU when set.
    logic mode;  // One selects edge-and-level triggering.
  } kpu_ctl_t;

  // --------------------------------------------------------------------------
  // One captured write-data beat.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } kpu_wbeat_t;

endpackage : kpu_pkg

// ---- kpu_regs.svh ----
// Register map, field positions, reset values and bus answers of the keypad unit.
// Assumes inclusion by the keypad unit module and its bench only.
//
// Contract
// - Five enable bits each select a wake pin.
// - Enabled pin turns on its pull-up.
// - Latch request when enabled pin falls, all high.
// - Edge mode ignores fall while another low.
// - Level mode clears after ack and all-high.
// - Vector fetch acknowledges like software.
// - Writing one acknowledges; bit reads zero.
// - Fall after acknowledge latches fresh request.
// - Unmasked pending request goes to CPU.
// - Edge mode acknowledge clears request at once.
// - Reset clears request and trigger mode.
// - Pending flag read-only, independent of mask.
// - Enable forces pin input over direction.
// - Mask bit blocks interrupts, resets to zero.
// - Mode one edge-and-level, zero edge only.
// - Active in wait and stop; wakes.
// - Break with clear disabled blocks acknowledges; vector fetch still acknowledges.
// - Upper status bits read zero; enables reset zero.
`ifndef KPU_REGS_SVH
`define KPU_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define KPU_SCR_IDX 8'h1a
`define KPU_IER_IDX 8'h1b

// ----------------------------------------------------------------------------
// Status and control field positions.
// ----------------------------------------------------------------------------
`define KPU_SCR_REQUEST_PENDING_FLAG 3
`define KPU_SCR_ACK 2
`define KPU_SCR_MASK 1
`define KPU_SCR_MODE 0

// ----------------------------------------------------------------------------
// Reset values and bus responses.
// ----------------------------------------------------------------------------
`define KPU_IER_RST 5'h00
`define KPU_RESP_OKAY 2'h0
`define KPU_RESP_SLVERR 2'h2

`endif

// ---- tb.sv ----
// Self-checking bench of the keypad unit, driving its AXI4-Lite registers and key pins.
// Assumes the package, register header, design and key model are compiled first.
`include "kpu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  import kpu_pkg::*;
  // --------------------------------------------------------------------------
  // Signals.
  // --------------------------------------------------------------------------
  localparam logic [7:0] SCR = 8'h68;  // Status and control, index 0x1a times four.
  localparam logic [7:0] IER = 8'h6c;  // Pin enables, index 0x1b times four.
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, vfa, brk, bce, cpu_take, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, r;
  logic [4:0] press, keys, wake_en, pull_en, force_in;
  logic [3:0] wstrb;
  int mismatches, n_checks;

  kpu_keypad_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .key_pin(keys), .vector_fetch_ack(vfa), .break_state(brk),
    .break_clear_enable(bce), .pin_wake_enable(wake_en), .pullup_en(pull_en),
    .force_input(force_in), .irq_req(irq));

  kpu_key_model u_keys (.aclk(aclk), .aresetn(aresetn), .press(press), .pullup_en(pull_en),
    .cpu_take(cpu_take), .irq_req(irq), .key_pin(keys), .vector_fetch_ack(vfa));

  // Free-running 250 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // --------------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  // Write one register byte; each channel is dropped once taken, the response ends it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    int i;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 40) begin
      mismatches++;
      give_verdict();
    end
    resp = bresp;
    bready <= 1'b0;
    // Let an edge pass so that a following call never raises bready in this time step.
    @(posedge aclk);
  endtask : wr

  // Read one register; data and response are taken at the edge that shows rvalid.
  task automatic rdr(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 40) begin
      mismatches++;
      give_verdict();
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    check(rd, exp);
  endtask : chk_reg

  // Key changes cross a two-flop synchroniser, so give them time to land.
  task automatic key(input logic [4:0] p);
    press <= p;
    step(6);
  endtask : key

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic t_reset_and_map();
    chk_reg(SCR, 32'h0);
    chk_reg(IER, 32'h0);
    check({27'h0, pull_en}, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h70, 8'hff, r);
    check({30'h0, r}, {30'h0, `KPU_RESP_SLVERR});
    rdr(8'h70);
    check({rd[31:2], rs}, {30'h0, `KPU_RESP_SLVERR});
  endtask : t_reset_and_map

  // Safe start-up order: mask, enable, acknowledge, unmask.
  task automatic t_init();
    wr(SCR, 8'h02, r);
    wr(IER, 8'hff, r);
    check({27'h0, wake_en}, 32'h1f);
    check({27'h0, pull_en}, 32'h1f);
    check({27'h0, force_in}, 32'h1f);
    chk_reg(IER, 32'h1f);
    wr(SCR, 8'hf6, r);
    chk_reg(SCR, 32'h02);
    wr(SCR, 8'h00, r);
  endtask : t_init

  task automatic t_edge_mode();
    key(5'h01);
    chk_reg(SCR, 32'h08);
    check({31'h0, irq}, 32'h1);
    wr(SCR, 8'h04, r);
    chk_reg(SCR, 32'h00);
    key(5'h03);
    chk_reg(SCR, 32'h00);
    key(5'h00);
    key(5'h04);
    chk_reg(SCR, 32'h08);
    cpu_take <= 1'b1;
    step(5);
    cpu_take <= 1'b0;
    chk_reg(SCR, 32'h00);
    key(5'h00);
  endtask : t_edge_mode

  // A masked request still shows in the flag, and reaches the CPU once unmasked.
  task automatic t_mask();
    wr(SCR, 8'h02, r);
    key(5'h10);
    chk_reg(SCR, 32'h0a);
    check({31'h0, irq}, 32'h0);
    wr(SCR, 8'h00, r);
    step(2);
    check({31'h0, irq}, 32'h1);
    wr(SCR, 8'h04, r);
    key(5'h00);
  endtask : t_mask

  // Level mode needs both the acknowledge and all pins high, in either order.
  task automatic t_level_mode();
    wr(SCR, 8'h01, r);
    key(5'h08);
    wr(SCR, 8'h05, r);
    chk_reg(SCR, 32'h09);
    key(5'h00);
    chk_reg(SCR, 32'h01);
    key(5'h08);
    key(5'h00);
    chk_reg(SCR, 32'h09);
    wr(SCR, 8'h05, r);
    chk_reg(SCR, 32'h01);
  endtask : t_level_mode

  task automatic t_break();
    wr(SCR, 8'h00, r);
    key(5'h02);
    key(5'h00);
    brk <= 1'b1;
    wr(SCR, 8'h04, r);
    chk_reg(SCR, 32'h08);
    bce <= 1'b1;
    wr(SCR, 8'h04, r);
    brk <= 1'b0;
    bce <= 1'b0;
    step(2);
    chk_reg(SCR, 32'h00);
  endtask : t_break

  // Pins left disabled have no pull-up and float, yet must never raise a request.
  task automatic t_disabled_pins();
    wr(IER, 8'h01, r);
    check({27'h0, wake_en}, 32'h01);
    // A write without byte lane 0 is answered but changes nothing.
    wstrb <= 4'h0;
    wr(IER, 8'h1f, r);
    wstrb <= 4'h1;
    check({30'h0, r}, {30'h0, `KPU_RESP_OKAY});
    check({27'h0, wake_en}, 32'h01);
    key(5'h1e);
    key(5'h00);
    chk_reg(SCR, 32'h00);
  endtask : t_disabled_pins

  task automatic t_reset_mid_run();
    wr(SCR, 8'h01, r);
    key(5'h01);
    chk_reg(SCR, 32'h09);
    aresetn <= 1'b0;
    step(2);
    aresetn <= 1'b1;
    step(1);
    chk_reg(SCR, 32'h00);
    chk_reg(IER, 32'h00);
    key(5'h00);
  endtask : t_reset_mid_run

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, brk, bce, cpu_take} = 9'h000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    press = 5'h00;
    mismatches = 0;
    n_checks = 0;
    step(3);
    aresetn <= 1'b1;
    step(1);
    t_reset_and_map();
    t_init();
    t_edge_mode();
    t_mask();
    t_level_mode();
    t_break();
    t_disabled_pins();
    t_reset_mid_run();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
